// ==== hw/spg_port.sv ====
// Six-pin general-purpose port with direction, pull-ups and change detection
//
// What this block does
// - six bidirectional pins, bits 7:6 read zero
// - direction one tristates the pin driver
// - direction zero drives output latch onto pin
// - pin three input only, direction reads one
// - data read gives pins, write read-modify-writes
// - pin three reads zero when master clear
// - analog-selected pins read zero in data
// - vref output disables pin one driver only
// - crystal mode: pins five, four read ones
// - pull-up needs own bit and global enable
// - pull-up off while pin is output
// - power-on reset leaves pull-ups globally off
// - master clear forces pin three pull-up
// - change enables cleared by power-on reset
// - enabled pin mismatches ORed into change flag
// - set change flag signals wake from sleep
// - data access refreshes last-read latch
// - persisting mismatch keeps re-setting the flag
// - last-read latch survives non-power-on resets
// - change at read instant still sets the flag
// - interrupt recognised only with global enable
// - output latches undefined after power-on
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module spg_port
	import spg_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [spg_pkg::SPG_ADDR_W+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [spg_pkg::SPG_DATA_W-1:0] wb_dat_i,
	output logic [spg_pkg::SPG_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins
	input wire logic [spg_pkg::SPG_PINS-1:0] pin_i,
	output logic [spg_pkg::SPG_PINS-1:0] pin_o,
	output logic [spg_pkg::SPG_PINS-1:0] pin_oe_o,
	output logic [spg_pkg::SPG_PINS-1:0] pullup_en_o,
	// Wake and interrupt
	output logic wake_o,
	output logic irq_o
);
	import spg_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [SPG_PINS-1:0] sync1_q;
	logic [SPG_PINS-1:0] sync2_q;
	logic [SPG_PINS-1:0] latch_q;
	logic [SPG_PINS-1:0] latch_d;
	logic [SPG_PINS-1:0] dir_q;
	logic [SPG_PINS-1:0] dir_d;
	logic [SPG_PINS-1:0] pullup_q;
	logic [SPG_PINS-1:0] pullup_d;
	logic [SPG_PINS-1:0] change_q;
	logic [SPG_PINS-1:0] change_d;
	logic [SPG_PINS-1:0] analog_q;
	logic [SPG_PINS-1:0] analog_d;
	logic [SPG_PINS-1:0] last_q;
	logic [SPG_PINS-1:0] last_d;
	logic [SPG_CTRL_W-1:0] ctrl_q;
	logic [SPG_CTRL_W-1:0] ctrl_d;
	logic flag_q;
	logic flag_d;
	logic ack_q;
	logic [SPG_DATA_W-1:0] rdata_q;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire logic [SPG_ADDR_W-1:0] idx = wb_adr_i[SPG_ADDR_W+1:2];
	wire logic req = wb_cyc_i & wb_stb_i & ~ack_q & ce_i;
	wire logic wr = req & wb_we_i & wb_sel_i[0];
	wire logic rd = req & ~wb_we_i;
	wire logic hit_data = idx == SPG_IDX_DATA;
	wire logic hit_dir = idx == SPG_IDX_DIR;
	wire logic hit_pullup = idx == SPG_IDX_PULLUP;
	wire logic hit_change = idx == SPG_IDX_CHANGE;
	wire logic hit_ctrl = idx == SPG_IDX_CTRL;
	wire logic hit_analog = idx == SPG_IDX_ANALOG;
	wire logic hit_status = idx == SPG_IDX_STATUS;
	wire logic [SPG_PINS-1:0] wbyte = wb_dat_i[SPG_PINS-1:0];
	wire logic flag_clr = wr & hit_status & ~wb_dat_i[SPG_STAT_FLAG];

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	wire logic global_pullup_control = ~ctrl_q[SPG_CTRL_PULLUP_OFF];
	wire logic master_clear_enable = ctrl_q[SPG_CTRL_MASTER_CLEAR_INPUT_EN];
	wire logic vref_out = ctrl_q[SPG_CTRL_VREF_OUT];
	wire logic xtal_mode = ctrl_q[SPG_CTRL_XTAL_MODE];
	wire logic global_interrupt_enable = ctrl_q[SPG_CTRL_GIE];
	wire logic [SPG_PINS-1:0] xtal_force = xtal_mode ? SPG_XTAL_PINS : '0;

	// Direction as seen by software and by the drivers
	wire logic [SPG_PINS-1:0] dir_eff = dir_q | SPG_INONLY_MASK | xtal_force;
	wire logic [SPG_PINS-1:0] pullup_rd = pullup_q | xtal_force;
	wire logic [SPG_PINS-1:0] change_rd = change_q | xtal_force;

	// ****************************************************************
	// Pin drivers and pull-ups
	// ****************************************************************
	wire logic [SPG_PINS-1:0] vref_mask = vref_out ? 6'h02 : 6'h00;
	assign pin_o = latch_q;
	assign pin_oe_o = ~dir_eff & ~vref_mask;

	wire logic [SPG_PINS-1:0] master_clear_input_pull = master_clear_enable ? SPG_INONLY_MASK : '0;
	// Output pins never pull; master clear forces pin three pull-up
	assign pullup_en_o = ((pullup_rd & dir_eff & {SPG_PINS{global_pullup_control}}))
		| master_clear_input_pull;

	// ****************************************************************
	// Pin read value
	// ****************************************************************
	// Analog pins and pin three under master clear read zero
	wire logic [SPG_PINS-1:0] pin_val = sync2_q & ~analog_q
		& ~(master_clear_enable ? SPG_INONLY_MASK : 6'h00);

	// ****************************************************************
	// Change detection
	// ****************************************************************
	// Compare uses the synchronised pins and the old last-read value; an edge that lands with the
	// refreshing access still sets the flag as the new last-read value is taken
	wire logic [SPG_PINS-1:0] mismatch_vec = (sync2_q ^ last_q) & change_rd;
	wire logic mismatch = |mismatch_vec;
	wire logic port_access = req & hit_data & (~wb_we_i | wb_sel_i[0]);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	assign latch_d = (wr & hit_data) ? ((pin_val & ~pin_oe_o) | (latch_q & pin_oe_o)) & wbyte
		| (wbyte & ~SPG_INONLY_MASK) & ~SPG_INONLY_MASK : latch_q;
	assign dir_d = (wr & hit_dir) ? wbyte : dir_q;
	assign pullup_d = (wr & hit_pullup) ? wbyte : pullup_q;
	assign change_d = (wr & hit_change) ? wbyte : change_q;
	assign analog_d = (wr & hit_analog) ? wbyte : analog_q;
	assign ctrl_d = (wr & hit_ctrl) ? wb_dat_i[SPG_CTRL_W-1:0] : ctrl_q;
	assign last_d = port_access ? sync2_q : last_q;
	// Set wins over clear, and a live mismatch keeps setting
	assign flag_d = mismatch | (flag_q & ~flag_clr);

	// ****************************************************************
	// Read mux
	// ****************************************************************
	logic [SPG_DATA_W-1:0] rmux;
	always_comb
	begin
		rmux = '0;
		unique case (1'b1)
			hit_data: rmux[SPG_PINS-1:0] = pin_val;
			hit_dir: rmux[SPG_PINS-1:0] = dir_eff;
			hit_pullup: rmux[SPG_PINS-1:0] = pullup_rd;
			hit_change: rmux[SPG_PINS-1:0] = change_rd;
			hit_ctrl: rmux[SPG_CTRL_W-1:0] = ctrl_q;
			hit_analog: rmux[SPG_PINS-1:0] = analog_q;
			hit_status:
			begin
				rmux[SPG_STAT_FLAG] = flag_q;
				rmux[SPG_STAT_IRQ] = irq_o;
			end
			default: rmux = '0;
		endcase
	end

	// ****************************************************************
	// Synchroniser and last-read latch (kept across non-power-on resets)
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (por_i)
			last_q <= SPG_LATCH_RST;
		else if (ce_i)
			last_q <= last_d;
	end

	// Output latch is not reset: undefined until software writes it
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
			latch_q <= latch_d;
	end

	// ****************************************************************
	// Power-on-only state
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			change_q <= SPG_CHANGE_RST;
			ctrl_q <= SPG_CTRL_RST;
		end
		else if (ce_i)
		begin
			change_q <= change_d;
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************************************
	// State reset by every reset
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i | por_i)
		begin
			dir_q <= SPG_DIR_RST;
			pullup_q <= SPG_PULLUP_RST;
			analog_q <= SPG_ANALOG_RST;
			flag_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= '0;
		end
		else if (ce_i)
		begin
			dir_q <= dir_d;
			pullup_q <= pullup_d;
			analog_q <= analog_d;
			flag_q <= flag_d;
			ack_q <= req;
			rdata_q <= rd ? rmux : rdata_q;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	assign wake_o = flag_q;
	assign irq_o = flag_q & global_interrupt_enable;

endmodule : spg_port

`default_nettype wire

// ==== hw/spg_pkg.sv ====
// Package for the six-pin port: register offsets, field layouts and reset values
package spg_pkg;

	localparam int unsigned SPG_PINS = 6;
	localparam int unsigned SPG_ADDR_W = 12;
	localparam int unsigned SPG_DATA_W = 32;

	// Word indices as printed; byte address is four times the index
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_DATA = 12'h005;
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_DIR = 12'h085;
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_PULLUP = 12'h095;
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_CHANGE = 12'h096;
	// Control and status registers with no printed offset
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_CTRL = 12'h0a0;
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_ANALOG = 12'h0a1;
	localparam logic [SPG_ADDR_W-1:0] SPG_IDX_STATUS = 12'h0a2;

	// Control register fields
	localparam int unsigned SPG_CTRL_PULLUP_OFF = 0;
	localparam int unsigned SPG_CTRL_MASTER_CLEAR_INPUT_EN = 1;
	localparam int unsigned SPG_CTRL_VREF_OUT = 2;
	localparam int unsigned SPG_CTRL_XTAL_MODE = 3;
	localparam int unsigned SPG_CTRL_GIE = 4;
	localparam int unsigned SPG_CTRL_W = 5;

	// Status register fields
	localparam int unsigned SPG_STAT_FLAG = 0;
	localparam int unsigned SPG_STAT_IRQ = 1;

	// Pin positions with special behaviour
	localparam int unsigned SPG_PIN_VREF = 1;
	localparam int unsigned SPG_PIN_INONLY = 3;
	localparam logic [SPG_PINS-1:0] SPG_XTAL_PINS = 6'h30;
	localparam logic [SPG_PINS-1:0] SPG_INONLY_MASK = 6'h08;

	// Values after reset
	localparam logic [SPG_PINS-1:0] SPG_DIR_RST = 6'h3f;
	localparam logic [SPG_PINS-1:0] SPG_PULLUP_RST = 6'h3f;
	localparam logic [SPG_PINS-1:0] SPG_CHANGE_RST = 6'h00;
	localparam logic [SPG_PINS-1:0] SPG_ANALOG_RST = 6'h3f;
	localparam logic [SPG_PINS-1:0] SPG_LATCH_RST = 6'h00;
	localparam logic [SPG_CTRL_W-1:0] SPG_CTRL_RST = 5'h01;

endpackage : spg_pkg

// ==== verification/spg_pins_model.sv ====
// Board-side model of the six port pins
`timescale 1ns/1ps
`default_nettype none

module spg_pins_model
(
	// Clock
	input wire logic clk_i,
	// Port side
	input wire logic [5:0] pin_o,
	input wire logic [5:0] pin_oe_o,
	input wire logic [5:0] pullup_en_o,
	// Board drive
	input wire logic [5:0] ext_val_i,
	input wire logic [5:0] ext_en_i,
	output logic [5:0] pin_lvl_o
);
	logic float_q = 1'b0;

	// Undriven pins without pull-up wander so a stale level never passes
	always_ff @(posedge clk_i)
	begin
		float_q <= !float_q;
	end

	assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
		| (~pin_oe_o & ~ext_en_i & (pullup_en_o | {6{float_q}}));
endmodule // spg_pins_model

`default_nettype wire

// ==== verification/spg_port_chk.sv ====
// Assertion checker for the six-pin port
`timescale 1ns/1ps
`default_nettype none

module spg_port_chk
(
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic ce_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins and events
	input wire logic [5:0] pin_oe_o,
	input wire logic [5:0] pullup_en_o,
	input wire logic wake_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);

	sequence s_taken;
		wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
	endsequence

	a_ack_pulse: assert property (s_taken |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one pulse");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_pin3_input: assert property (!pin_oe_o[3]) else $error("pin 3 driven");
	a_pullup_output: assert property ((pin_oe_o & pullup_en_o) == 6'h00)
		else $error("pull-up on output");
	a_irq_wake: assert property (irq_o |-> wake_o) else $error("irq without flag");
	a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:6] == 26'h0)
		else $error("upper bits set");
	a_por_state: assert property ($fell(por_i) |-> pullup_en_o == 6'h00 && pin_oe_o == 6'h00)
		else $error("state after power-on");
	a_flag_held: assert property ($fell(wake_o) && !$past(rst_i) |-> $past(wb_stb_i && wb_we_i))
		else $error("flag lost without write");
endmodule // spg_port_chk

bind spg_port spg_port_chk u_chk (.clk_i, .rst_i, .por_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_dat_o, .wb_ack_o, .pin_oe_o, .pullup_en_o, .wake_o, .irq_o);

`default_nettype wire

// ==== verification/tb_spg_port.sv ====
// Self-checking bench for the six-pin port
`timescale 1ns/1ps
`default_nettype none

module tb_spg_port;
	import spg_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [13:0] adr = 14'h0;
	logic [31:0] wd = 32'h0, rd;
	logic [5:0] ev = 6'h00, ee = 6'h3f, lvl, po, oe, pu;
	logic ack, wake, irq;
	int err_count = 0;
	int comparisons = 0;

	always #12.5 clk_i = !clk_i;

	spg_port dut (.clk_i, .rst_i, .por_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .pin_i(lvl), .pin_o(po), .pin_oe_o(oe), .pullup_en_o(pu),
		.wake_o(wake), .irq_o(irq));
	spg_pins_model brd (.clk_i, .pin_o(po), .pin_oe_o(oe), .pullup_en_o(pu), .ext_val_i(ev),
		.ext_en_i(ee), .pin_lvl_o(lvl));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled high
	task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wd <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rc(input string nm, input logic [11:0] idx, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		chk(nm, e, q);
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (4000) @(posedge clk_i);
		err_count++;
		final_report();
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		rc("dir", SPG_IDX_DIR, 32'h3f);
		rc("pullup", SPG_IDX_PULLUP, 32'h3f);
		rc("change", SPG_IDX_CHANGE, 32'h0);
		rc("hole", 12'h3ff, 32'h0);
		chk("pu", 32'h0, {26'h0, pu});
		ee <= 6'h08;
		ev <= 6'h08;
		wr(SPG_IDX_DATA, 32'h15);
		wr(SPG_IDX_DIR, 32'h0);
		rc("dir", SPG_IDX_DIR, 32'h08);
		chk("oe", 32'h37, {26'h0, oe});
		rc("analog", SPG_IDX_DATA, 32'h0);
		wr(SPG_IDX_ANALOG, 32'h0);
		rc("data", SPG_IDX_DATA, 32'h1d);
		wr(SPG_IDX_PULLUP, 32'h0);
		wr(SPG_IDX_CTRL, 32'h02);
		rc("data", SPG_IDX_DATA, 32'h15);
		chk("pu", 32'h08, {26'h0, pu});
		wr(SPG_IDX_CTRL, 32'h0);
		chk("pu", 32'h0, {26'h0, pu});
		wr(SPG_IDX_PULLUP, 32'h3f);
		chk("pu", 32'h08, {26'h0, pu});
		wr(SPG_IDX_CTRL, 32'h04);
		chk("oe", 32'h35, {26'h0, oe});
		rc("dir", SPG_IDX_DIR, 32'h08);
		wr(SPG_IDX_CTRL, 32'h08);
		rc("dir", SPG_IDX_DIR, 32'h38);
		rc("change", SPG_IDX_CHANGE, 32'h30);
		chk("oe", 32'h07, {26'h0, oe});
		wr(SPG_IDX_CTRL, 32'h0);
		wr(SPG_IDX_DIR, 32'h3f);
		ee <= 6'h3f;
		ev <= 6'h00;
		wr(SPG_IDX_CHANGE, 32'h01);
		rc("data", SPG_IDX_DATA, 32'h0);
		// Crystal mode pulled pins five and four high and set the flag; clear it first
		wr(SPG_IDX_STATUS, 32'h0);
		rc("flag", SPG_IDX_STATUS, 32'h0);
		ev <= 6'h01;
		repeat (4) @(posedge clk_i);
		rc("flag", SPG_IDX_STATUS, 32'h01);
		chk("wake", 32'h1, {31'h0, wake});
		wr(SPG_IDX_STATUS, 32'h0);
		rc("flag", SPG_IDX_STATUS, 32'h01);
		wr(SPG_IDX_CTRL, 32'h10);
		rc("flag", SPG_IDX_STATUS, 32'h03);
		rc("data", SPG_IDX_DATA, 32'h01);
		wr(SPG_IDX_STATUS, 32'h0);
		rc("flag", SPG_IDX_STATUS, 32'h0);
		ev <= 6'h03;
		repeat (4) @(posedge clk_i);
		rc("flag", SPG_IDX_STATUS, 32'h0);
		ev <= 6'h02;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rc("flag", SPG_IDX_STATUS, 32'h03);
		final_report();
	end
endmodule // tb_spg_port

`default_nettype wire
